//--- rtl/dcm_reg_bank.sv
// Register bank of the dual card mux behind a two-wire serial target port
// Operation
// - Read-only identification byte at offset zero
// - Maker code sits in upper nibble
// - Maker nibble fixed across hardware revisions
// - Read-only driver version byte at offset one
// - Driver version constant unless software must change
// - Driver version reads zero initially
// - Two debounce registers, reset to four
// - Interrupt flags clear when status is read
// - Host reaches registers over serial target port
`timescale 1ns/100ps
module dcm_reg_bank
   import dcm_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h2a,  // Arbitrary target address
   parameter logic [3:0] MFR_ID   = 4'h5,   // Arbitrary maker code
   parameter logic [3:0] DEV_REV  = 4'h3    // Arbitrary device and revision code
) (
   // Clock, reset, enable
   input  wire logic                      ref_clk,
   input  wire logic                      rst,
   input  wire logic                      ce,
   // Serial target pins
   input  wire logic                      sclIn,
   input  wire logic                      sdaIn,
   output logic                           sdaOut,
   output logic                           sdaOe,
   // Monitored inputs
   input  wire logic                      batteryPresenceInput,
   input  wire logic                      shutdownRequestInput,
   // Control register contents
   output logic      [dcm_pkg::DATA_W-1:0] cardSlotCtrl,
   output logic      [dcm_pkg::DATA_W-1:0] clockSourceCtrl,
   output logic      [dcm_pkg::DATA_W-1:0] detDirCtrl,
   output logic      [dcm_pkg::DATA_W-1:0] pullConfig
);
   import dcm_pkg::*;

   localparam logic [7:0] HW_ID = {MFR_ID, DEV_REV};

   // Pin synchronisers and edge history
   logic [1:0]        sclSync, sdaSync;        // Two-stage synchronisers
   logic              sclQ, sdaQ;              // Previous synchronised level
   logic [1:0]        batSync, sdnSync;        // Monitored input synchronisers
   // Serial engine state
   dcm_state_t        state_r;                 // Engine state
   logic [3:0]        bitCnt_r;                // Bits seen in current byte
   logic [7:0]        rxShift_r;               // Received byte
   logic [7:0]        txShift_r;               // Byte being sent
   logic [7:0]        ptr_r;                   // Register pointer
   logic              firstByte_r;             // Next write byte is the pointer
   logic              readMode_r;              // Transfer direction
   logic              masterAck_r;             // Host acknowledged last byte
   // Registers
   logic [7:0]        slot_r, batDeb_r, sdnDeb_r, clk_r, devCtl_r, pull_r;
   logic              batInt_r, sdnInt_r;      // Sticky interrupt flags
   logic [1:0]        stable_r;                // Debounced levels: 0 battery, 1 shutdown
   logic [7:0]        debCnt_r [2];            // Debounce counters
   // Combinational helpers
   logic              sclRise, sclFall, startCond, stopCond;
   logic              loadTx, wrEn, statusRead;
   logic [7:0]        rdByte, statusByte, memRdData;
   logic [1:0]        inLvl, debDone;
   logic              batEvt, sdnEvt, memWr;

   // Synchronise every pin before use
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sclSync <= 2'h3;
         sdaSync <= 2'h3;
         sclQ    <= 1'b1;
         sdaQ    <= 1'b1;
         batSync <= 2'h0;
         sdnSync <= 2'h0;
      end else if (ce) begin
         sclSync <= {sclSync[0], sclIn};
         sdaSync <= {sdaSync[0], sdaIn};
         sclQ    <= sclSync[1];
         sdaQ    <= sdaSync[1];
         batSync <= {batSync[0], batteryPresenceInput};
         sdnSync <= {sdnSync[0], shutdownRequestInput};
      end
   end

   // Bus conditions, only from second synchroniser stage on
   assign sclRise   = sclSync[1] & ~sclQ;
   assign sclFall   = ~sclSync[1] & sclQ;
   assign startCond = sclSync[1] & sclQ & sdaQ & ~sdaSync[1];
   assign stopCond  = sclSync[1] & sclQ & ~sdaQ & sdaSync[1];
   assign inLvl     = {sdnSync[1], batSync[1]};

   // Load a read byte after address ack or after host ack
   assign loadTx     = ce && !startCond && !stopCond && sclFall &&
                       (((state_r == S_ACK) && readMode_r) || ((state_r == S_MACK) && masterAck_r));
   assign wrEn       = ce && !startCond && !stopCond && sclFall && (state_r == S_WRITE) &&
                       (bitCnt_r == BYTE_BITS) && !firstByte_r;
   assign statusRead = loadTx && (ptr_r == REG_STATUS);
   assign memWr      = wrEn && (ptr_r >= REG_TEST_LO) && (ptr_r <= REG_TEST_HI);

   // Serial target engine
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_r     <= S_IDLE;
         bitCnt_r    <= '0;
         rxShift_r   <= '0;
         txShift_r   <= '0;
         ptr_r       <= RST_ZERO;
         firstByte_r <= 1'b0;
         readMode_r  <= 1'b0;
         masterAck_r <= 1'b0;
         sdaOe       <= 1'b0;
      end else if (ce) begin
         if (startCond) begin
            // Start or repeated start always restarts address phase
            state_r  <= S_ADDR;
            bitCnt_r <= '0;
            sdaOe    <= 1'b0;
         end else if (stopCond) begin
            state_r <= S_IDLE;
            sdaOe   <= 1'b0;
         end else begin
            case (state_r)
               S_ADDR, S_WRITE: begin
                  if (sclRise) begin
                     rxShift_r <= {rxShift_r[6:0], sdaSync[1]};
                     bitCnt_r  <= 4'(bitCnt_r + 4'h1);
                  end else if (sclFall && (bitCnt_r == BYTE_BITS)) begin
                     if (state_r == S_WRITE) begin
                        // First byte sets pointer, later bytes advance it
                        ptr_r       <= firstByte_r ? rxShift_r : 8'(ptr_r + 8'h01);
                        firstByte_r <= 1'b0;
                        sdaOe       <= 1'b1;
                        state_r     <= S_ACK;
                     end else if (rxShift_r[7:1] == DEV_ADDR) begin
                        readMode_r  <= rxShift_r[0];
                        firstByte_r <= 1'b1;
                        sdaOe       <= 1'b1;
                        state_r     <= S_ACK;
                     end else begin
                        // Another target addressed: stay off the bus
                        state_r <= S_IDLE;
                     end
                  end
               end
               S_ACK: begin
                  if (sclFall) begin
                     bitCnt_r <= '0;
                     if (readMode_r) begin
                        txShift_r <= rdByte;
                        sdaOe     <= ~rdByte[7];
                        ptr_r     <= 8'(ptr_r + 8'h01);
                        state_r   <= S_READ;
                     end else begin
                        sdaOe   <= 1'b0;
                        state_r <= S_WRITE;
                     end
                  end
               end
               S_READ: begin
                  if (sclRise) begin
                     bitCnt_r <= 4'(bitCnt_r + 4'h1);
                  end else if (sclFall) begin
                     if (bitCnt_r == BYTE_BITS) begin
                        // Release line for host ack
                        sdaOe   <= 1'b0;
                        state_r <= S_MACK;
                     end else begin
                        txShift_r <= {txShift_r[6:0], 1'b0};
                        sdaOe     <= ~txShift_r[6];
                     end
                  end
               end
               S_MACK: begin
                  if (sclRise) begin
                     masterAck_r <= ~sdaSync[1];
                  end else if (sclFall) begin
                     if (masterAck_r) begin
                        bitCnt_r  <= '0;
                        txShift_r <= rdByte;
                        sdaOe     <= ~rdByte[7];
                        ptr_r     <= 8'(ptr_r + 8'h01);
                        state_r   <= S_READ;
                     end else begin
                        // Host nack ends the read
                        state_r <= S_IDLE;
                     end
                  end
               end
               default: begin
                  state_r <= S_IDLE;
               end
            endcase
         end
      end
   end

   // Open-drain line: only the enable toggles, data is always low
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sdaOut <= 1'b0;
      end else if (ce) begin
         sdaOut <= 1'b0;
      end
   end

   // Status byte assembly
   always_comb begin
      statusByte                       = RST_ZERO;
      statusByte[ST_SDN_LVL]           = inLvl[1];
      statusByte[ST_SDN_INT]           = sdnInt_r;
      statusByte[ST_BAT_LVL]           = stable_r[0];
      statusByte[ST_BAT_INT]           = batInt_r;
      statusByte[ST_SIM1_LO +: 2]      = dcm_sim_status(slot_r[SLOT_STATE1 +: 2], slot_r[SLOT_REG1]);
      statusByte[ST_SIM2_LO +: 2]      = dcm_sim_status(slot_r[SLOT_STATE2 +: 2], slot_r[SLOT_REG2]);
   end

   // Read decode; reserved and unmapped offsets read zero
   always_comb begin
      if (ptr_r == REG_HWID) begin
         rdByte = HW_ID;
      end else if (ptr_r == REG_DRV) begin
         rdByte = DRV_VERSION;
      end else if (ptr_r == REG_STATUS) begin
         rdByte = statusByte;
      end else if (ptr_r == REG_SLOT) begin
         rdByte = slot_r;
      end else if (ptr_r == REG_BATDEB) begin
         rdByte = batDeb_r;
      end else if (ptr_r == REG_SDNDEB) begin
         rdByte = sdnDeb_r;
      end else if (ptr_r == REG_CLKSRC) begin
         rdByte = clk_r;
      end else if (ptr_r == REG_DEVCTL) begin
         rdByte = devCtl_r;
      end else if ((ptr_r >= REG_TEST_LO) && (ptr_r <= REG_TEST_HI)) begin
         rdByte = memRdData;
      end else if (ptr_r == REG_PULL) begin
         rdByte = pull_r;
      end else begin
         rdByte = RST_ZERO;
      end
   end

   // Writable registers; read-only offsets have no branch and keep their value
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         slot_r   <= RST_ZERO;
         batDeb_r <= RST_DEB;
         sdnDeb_r <= RST_DEB;
         clk_r    <= RST_ZERO;
         devCtl_r <= RST_ZERO;
         pull_r   <= RST_ZERO;
      end else if (wrEn) begin
         if (ptr_r == REG_SLOT) begin
            slot_r <= rxShift_r;
         end else if (ptr_r == REG_BATDEB) begin
            batDeb_r <= rxShift_r;
         end else if (ptr_r == REG_SDNDEB) begin
            sdnDeb_r <= rxShift_r;
         end else if (ptr_r == REG_CLKSRC) begin
            clk_r <= rxShift_r & CLKSRC_MASK;
         end else if (ptr_r == REG_DEVCTL) begin
            devCtl_r <= rxShift_r;
         end else if (ptr_r == REG_PULL) begin
            pull_r <= rxShift_r & PULL_MASK;
         end
      end
   end

   // Factory test bytes
   dcm_test_mem #(
      .DATA_W (DATA_W),
      .DEPTH  (TEST_DEPTH),
      .AW     (TEST_AW)
   ) u_test_mem (
      .ref_clk (ref_clk),
      .rst     (rst),
      .ce      (ce),
      .wrEn    (memWr),
      .wrAddr  (TEST_AW'(ptr_r - REG_TEST_LO)),
      .wrData  (rxShift_r),
      .rdAddr  (TEST_AW'(ptr_r - REG_TEST_LO)),
      .rdData  (memRdData)
   );

   // Debounce: a new level must hold past the programmed count
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         debDone[i] = (inLvl[i] != stable_r[i]) && (debCnt_r[i] >= (i == 0 ? batDeb_r : sdnDeb_r));
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         stable_r <= 2'h0;
         for (int i = 0; i < 2; i++) begin
            debCnt_r[i] <= RST_ZERO;
         end
      end else if (ce) begin
         for (int i = 0; i < 2; i++) begin
            if (inLvl[i] == stable_r[i]) begin
               debCnt_r[i] <= RST_ZERO;
            end else if (debDone[i]) begin
               stable_r[i] <= inLvl[i];
               debCnt_r[i] <= RST_ZERO;
            end else begin
               debCnt_r[i] <= 8'(debCnt_r[i] + 8'h01);
            end
         end
      end
   end

   // Events: battery loss, and any settled shutdown change
   assign batEvt = debDone[0] && inLvl[0] && devCtl_r[DC_BAT_IEN];
   assign sdnEvt = debDone[1] && devCtl_r[DC_SDN_IEN];

   // Sticky flags; a new event beats the read clear in the same cycle
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         batInt_r <= 1'b0;
         sdnInt_r <= 1'b0;
      end else if (ce) begin
         batInt_r <= batEvt | (batInt_r & ~statusRead);
         sdnInt_r <= sdnEvt | (sdnInt_r & ~statusRead);
      end
   end

   // Register contents out
   assign cardSlotCtrl    = slot_r;
   assign clockSourceCtrl = clk_r;
   assign detDirCtrl      = devCtl_r;
   assign pullConfig      = pull_r;

   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence q_addrHit;
      ce && sclFall && (state_r == S_ADDR) && (bitCnt_r == BYTE_BITS) && (rxShift_r[7:1] == DEV_ADDR);
   endsequence
   sequence q_ackDriven;
      (state_r == S_ACK) && sdaOe;
   endsequence

   property p_hwid;
      loadTx && (ptr_r == REG_HWID) |=> (txShift_r == HW_ID);
   endproperty
   a_hwid: assert property (p_hwid) else $error("identification byte wrong");
   property p_mfrNibble;
      loadTx && (ptr_r == REG_HWID) |=> (txShift_r[7:4] == MFR_ID) && sdaOe == ~MFR_ID[3];
   endproperty
   a_mfrNibble: assert property (p_mfrNibble) else $error("maker nibble wrong");
   // Maker nibble comes only from its own parameter, whatever the revision code
   property p_mfrStable;
      (ptr_r == REG_HWID) |-> (rdByte[7:4] == MFR_ID) && (rdByte[3:0] == DEV_REV);
   endproperty
   a_mfrStable: assert property (p_mfrStable) else $error("maker nibble changed");
   property p_drv;
      loadTx && (ptr_r == REG_DRV) |=> (txShift_r == DRV_VERSION) && (sdaOe == ~DRV_VERSION[7]);
   endproperty
   a_drv: assert property (p_drv) else $error("driver version byte wrong");
   property p_drvConst;
      (ptr_r == REG_DRV) |-> (rdByte == DRV_VERSION);
   endproperty
   a_drvConst: assert property (p_drvConst) else $error("driver version not constant");
   property p_drvZero;
      (ptr_r == REG_DRV) |-> (rdByte == 8'h00);
   endproperty
   a_drvZero: assert property (p_drvZero) else $error("driver version not zero");
   property p_debReset;
      disable iff (1'b0) rst |=> (batDeb_r == RST_DEB) && (sdnDeb_r == RST_DEB);
   endproperty
   a_debReset: assert property (p_debReset) else $error("debounce reset value wrong");
   property p_clearOnRead;
      statusRead && !batEvt && !sdnEvt |=> !batInt_r && !sdnInt_r;
   endproperty
   a_clearOnRead: assert property (p_clearOnRead) else $error("flags not cleared by read");
   property p_setWins;
      ce && batEvt |=> batInt_r;
   endproperty
   a_setWins: assert property (p_setWins) else $error("battery event lost");
   property p_addrAck;
      q_addrHit |=> q_ackDriven;
   endproperty
   a_addrAck: assert property (p_addrAck) else $error("address not acknowledged");
   property p_roWrite;
      wrEn && ((ptr_r == REG_HWID) || (ptr_r == REG_DRV) || (ptr_r == REG_STATUS) || (ptr_r == REG_RSVD))
         |=> $stable(slot_r) && $stable(batDeb_r) && $stable(sdnDeb_r) && $stable(devCtl_r) && $stable(pull_r);
   endproperty
   a_roWrite: assert property (p_roWrite) else $error("read-only write disturbed a register");
endmodule : dcm_reg_bank

//--- rtl/dcm_pkg.sv
// Register map constants, field positions and state type of the dual card mux register bank
package dcm_pkg;
   // Data width of every register
   localparam int          DATA_W        = 8;
   // Register offsets
   localparam logic [7:0]  REG_HWID      = 8'h00;
   localparam logic [7:0]  REG_DRV       = 8'h01;
   localparam logic [7:0]  REG_STATUS    = 8'h04;
   localparam logic [7:0]  REG_SLOT      = 8'h08;
   localparam logic [7:0]  REG_BATDEB    = 8'h0a;
   localparam logic [7:0]  REG_SDNDEB    = 8'h0b;
   localparam logic [7:0]  REG_RSVD      = 8'h0c;
   localparam logic [7:0]  REG_CLKSRC    = 8'h0d;
   localparam logic [7:0]  REG_DEVCTL    = 8'h0e;
   localparam logic [7:0]  REG_TEST_LO   = 8'h10;
   localparam logic [7:0]  REG_TEST_HI   = 8'h14;
   localparam logic [7:0]  REG_PULL      = 8'h15;
   // Reset and fixed values
   localparam logic [7:0]  RST_ZERO      = 8'h00;
   localparam logic [7:0]  RST_DEB       = 8'h04;
   localparam logic [7:0]  DRV_VERSION   = 8'h00;
   // Implemented bits of partly reserved registers
   localparam logic [7:0]  CLKSRC_MASK   = 8'h80;
   localparam logic [7:0]  PULL_MASK     = 8'h03;
   // Status register fields
   localparam int          ST_SDN_LVL    = 0;
   localparam int          ST_SDN_INT    = 1;
   localparam int          ST_BAT_LVL    = 2;
   localparam int          ST_BAT_INT    = 3;
   localparam int          ST_SIM1_LO    = 4;
   localparam int          ST_SIM2_LO    = 6;
   // Card slot control fields
   localparam int          SLOT_REG1     = 0;
   localparam int          SLOT_STATE1   = 2;
   localparam int          SLOT_REG2     = 4;
   localparam int          SLOT_STATE2   = 6;
   // Device control fields
   localparam int          DC_BAT_IEN    = 2;
   localparam int          DC_SDN_IEN    = 5;
   // Serial link and test storage constants
   localparam logic [3:0]  BYTE_BITS     = 4'h8;
   localparam int          TEST_AW       = 3;
   localparam int          TEST_DEPTH    = 5;

   // Serial target states
   typedef enum logic [5:0] {
      S_IDLE  = 6'b000001,
      S_ADDR  = 6'b000010,
      S_ACK   = 6'b000100,
      S_WRITE = 6'b001000,
      S_READ  = 6'b010000,
      S_MACK  = 6'b100000
   } dcm_state_t;

   // Slot status from state bits and regulator bit
   function automatic logic [1:0] dcm_sim_status(input logic [1:0] st, input logic regOn);
      if (!regOn) begin
         dcm_sim_status = 2'h0;
      end else if (st == 2'h0) begin
         dcm_sim_status = 2'h2;
      end else begin
         dcm_sim_status = st;
      end
   endfunction : dcm_sim_status
endpackage : dcm_pkg

//--- rtl/dcm_test_mem.sv
// Small storage for the factory test bytes with registered read data
`timescale 1ns/100ps
module dcm_test_mem #(
   parameter int DATA_W = 8,
   parameter int DEPTH  = 5,
   parameter int AW     = 3
) (
   // Clock, reset, enable
   input  wire logic              ref_clk,
   input  wire logic              rst,
   input  wire logic              ce,
   // Write side
   input  wire logic              wrEn,
   input  wire logic [AW-1:0]     wrAddr,
   input  wire logic [DATA_W-1:0] wrData,
   // Read side
   input  wire logic [AW-1:0]     rdAddr,
   output logic      [DATA_W-1:0] rdData
);
   // Storage cells, undefined after power-up
   logic [DATA_W-1:0] mem [DEPTH];

   // Write port
   always_ff @(posedge ref_clk) begin
      if (ce && wrEn && (int'(wrAddr) < DEPTH)) begin
         mem[wrAddr] <= wrData;
      end
   end

   // Registered read, zero outside the array
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdData <= '0;
      end else if (ce) begin
         rdData <= (int'(rdAddr) < DEPTH) ? mem[rdAddr] : '0;
      end
   end
endmodule : dcm_test_mem

//--- tb/dcm_host_model.sv
// Serial bus controller model standing in for the host processor
`timescale 1ns/100ps
module dcm_host_model #(
   parameter int HALF = 32  // Half bit in clocks, about 390 kb/s at 25 MHz
) (
   // Clock
   input  wire logic ref_clk,
   // Bus wires
   input  wire logic sdaLine,
   output logic      sclDrv,
   output logic      sdaLow
);
   // Bus idle: clock high, data released
   initial begin
      sclDrv = 1'b1;
      sdaLow = 1'b0;
   end

   // Whole clock cycles
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : tick

   // One bit; data moves well after the clock fall so the target hold is met
   task automatic bit_slot(input logic val, output logic seen);
      sclDrv <= 1'b0;
      tick(8);
      sdaLow <= ~val;
      tick(HALF - 8);
      sclDrv <= 1'b1;
      tick(HALF / 2);
      seen = sdaLine;
      tick(HALF / 2);
   endtask : bit_slot

   // Start or repeated start: data falls while clock high
   task automatic start_cond;
      sclDrv <= 1'b0;
      tick(8);
      sdaLow <= 1'b0;
      tick(HALF - 8);
      sclDrv <= 1'b1;
      tick(HALF);
      sdaLow <= 1'b1;
      tick(HALF);
   endtask : start_cond

   // Stop: data rises while clock high
   task automatic stop_cond;
      sclDrv <= 1'b0;
      tick(8);
      sdaLow <= 1'b1;
      tick(HALF - 8);
      sclDrv <= 1'b1;
      tick(HALF);
      sdaLow <= 1'b0;
      tick(HALF);
   endtask : stop_cond

   // Byte out, MSB first, then sample target acknowledge
   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_slot(b[i], s);
      bit_slot(1'b1, s);
      ack = ~s;
   endtask : send_byte

   // Byte in; acknowledge unless last, which is refused to end the read
   task automatic recv_byte(input logic last, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_slot(1'b1, s);
         b[i] = s;
      end
      bit_slot(last, s);
   endtask : recv_byte
endmodule : dcm_host_model

//--- tb/dcm_reg_bank_tb.sv
// Register-level testbench of the dual card mux register bank
`timescale 1ns/100ps
module dcm_reg_bank_tb;
   import dcm_pkg::*;
   localparam logic [6:0] ADDR = 7'h2a;  // Target address
   localparam logic [3:0] MFR  = 4'h6;   // Arbitrary maker code
   localparam logic [3:0] REV  = 4'h1;   // Arbitrary revision code
   logic        ref_clk  = 1'b0;  // Bench clock
   logic        rst      = 1'b1;  // Synchronous reset
   logic        batIn    = 1'b0;  // Battery-absent pin
   logic        sdnIn    = 1'b0;  // Shutdown pin
   logic        sclDrv;           // Host clock line
   logic        sdaLow;           // Host pulls data low
   logic        sdaOut;           // Target data value
   logic        sdaOe;            // Target pulls data
   logic        sdaLine;          // Resolved data wire
   logic [7:0]  slotCtrl;         // Slot control contents
   logic [7:0]  detCtrl;          // Device control contents
   logic [7:0]  clkCtrl;          // Clock source contents
   logic [7:0]  pullCtrl;         // Pull configuration contents
   logic [15:0] rd;               // Read result
   logic        ack;              // Target acknowledge of last byte sent
   int          fail_count = 0;   // Mismatches
   int          cmp_count  = 0;   // Comparisons

   // 25 MHz clock
   always #20 ref_clk = ~ref_clk;
   // Open-drain wire with pull-up
   assign sdaLine = ((sdaOe && !sdaOut) || sdaLow) ? 1'b0 : 1'b1;

   dcm_reg_bank #(.DEV_ADDR(ADDR), .MFR_ID(MFR), .DEV_REV(REV)) uut (
      .ref_clk(ref_clk), .rst(rst), .ce(1'b1), .sclIn(sclDrv), .sdaIn(sdaLine),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .batteryPresenceInput(batIn),
      .shutdownRequestInput(sdnIn), .cardSlotCtrl(slotCtrl), .clockSourceCtrl(clkCtrl),
      .detDirCtrl(detCtrl), .pullConfig(pullCtrl));

   dcm_host_model host (.ref_clk(ref_clk), .sdaLine(sdaLine), .sclDrv(sclDrv), .sdaLow(sdaLow));

   // Compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t %s: saw %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   // Pointer then n data bytes, pointer auto-increments
   task automatic write_regs(input logic [7:0] ptr, input logic [15:0] data, input int n);
      host.start_cond();
      host.send_byte({ADDR, 1'b0}, ack);
      check({15'h0, ack}, 16'h1, "address ack");
      host.send_byte(ptr, ack);
      check({15'h0, ack}, 16'h1, "pointer ack");
      for (int i = n - 1; i >= 0; i--) begin
         host.send_byte(data[8*i +: 8], ack);
         check({15'h0, ack}, 16'h1, "data ack");
      end
      host.stop_cond();
   endtask : write_regs

   // Set pointer, repeated start, read n bytes
   task automatic read_regs(input logic [7:0] ptr, input int n, output logic [15:0] v);
      logic [7:0] b;
      v = 16'h0;
      host.start_cond();
      host.send_byte({ADDR, 1'b0}, ack);
      host.send_byte(ptr, ack);
      host.start_cond();
      host.send_byte({ADDR, 1'b1}, ack);
      check({15'h0, ack}, 16'h1, "read address ack");
      for (int i = 0; i < n; i++) begin
         host.recv_byte(i == n - 1, b);
         v = {v[7:0], b};
      end
      host.stop_cond();
   endtask : read_regs

   // Verdict and end of run
   task automatic tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : tally_and_finish

   // Hang guard
   initial begin
      repeat (100000) @(posedge ref_clk);
      fail_count++;
      $display("[FAIL] %0t run did not complete", $time);
      tally_and_finish();
   end

   // Main sequence
   initial begin
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (5) @(posedge ref_clk);
      read_regs(REG_HWID, 2, rd);
      check(rd, {MFR, REV, 8'h00}, "identity bytes");
      read_regs(REG_BATDEB, 2, rd);
      check(rd, 16'h0404, "debounce reset");
      $display("test reset values done");
      write_regs(REG_HWID, 16'h5aa5, 2);
      read_regs(REG_HWID, 2, rd);
      check(rd, {MFR, REV, 8'h00}, "read-only kept");
      write_regs(REG_RSVD, 16'h00ff, 1);
      read_regs(REG_RSVD, 1, rd);
      check(rd, 16'h0000, "reserved reads zero");
      $display("test read-only done");
      write_regs(REG_BATDEB, 16'h07ff, 2);
      read_regs(REG_BATDEB, 2, rd);
      check(rd, 16'h07ff, "debounce write");
      $display("test debounce regs done");
      // Clock source and pull bytes keep only their implemented bits
      write_regs(REG_CLKSRC, 16'h00ff, 1);
      write_regs(REG_PULL, 16'h00ff, 1);
      check({clkCtrl, pullCtrl}, 16'h8003, "masked control outputs");
      // Test bytes behave as plain storage
      write_regs(REG_TEST_LO, 16'hc33c, 2);
      read_regs(REG_TEST_LO, 2, rd);
      check(rd, 16'hc33c, "test bytes");
      $display("test storage done");
      // Slot 1 active, slot 2 powered while its state bits stay 00
      write_regs(REG_SLOT, 16'h001d, 1);
      write_regs(REG_DEVCTL, 16'h0024, 1);
      check({slotCtrl, detCtrl}, 16'h1d24, "control outputs");
      read_regs(REG_STATUS, 1, rd);
      check(rd, 16'h00b0, "quiet status");
      batIn <= 1'b1;
      repeat (400) @(posedge ref_clk);
      read_regs(REG_STATUS, 1, rd);
      check(rd, 16'h00bc, "battery event");
      read_regs(REG_STATUS, 1, rd);
      check(rd, 16'h00b4, "battery flag cleared");
      sdnIn <= 1'b1;
      repeat (400) @(posedge ref_clk);
      read_regs(REG_STATUS, 1, rd);
      check(rd, 16'h00b7, "shutdown event");
      read_regs(REG_STATUS, 1, rd);
      check(rd, 16'h00b5, "shutdown flag cleared");
      $display("test status events done");
      host.start_cond();
      host.send_byte({ADDR ^ 7'h01, 1'b0}, ack);
      check({15'h0, ack}, 16'h0, "foreign address ignored");
      host.stop_cond();
      $display("test address mismatch done");
      tally_and_finish();
   end
endmodule : dcm_reg_bank_tb
